// [rom_ctrl.sv]
// rom_ctrl.sv: receive line/section overhead monitor flags, masks, control and defect persistence.
// assumes: frame strobe, framing result and k2 bits come from the framer, synchronous to clk_i.
//
// What this block does
// RULE_01: set change flag when event state changes
// RULE_02: line flags hold until written one
// RULE_03: section flags clear by per-bit one write
// RULE_04: line flag bits 7,5,4,3,2,1; 6,0 reserved
// RULE_05: section flag bits 5,3,2; others zero
// RULE_06: set mask bit suppresses that flag's report
// RULE_07: software writes ones to line mask 6,0
// RULE_08: four-bit k2 persistence count, reset 0101
// RULE_09: polarity bit selects active-low loss indication
// RULE_10: inhibit bit blocks loss from rdi
// RULE_11: framer bit one enables internal framer
// RULE_12: framer off, source supplies frame pulse
// RULE_13: frame loss clears after 8/24 good frames
// RULE_14: four-bit alignment code, reset zero
// RULE_15: alignment codes 0000 to 1011 defined
// RULE_16: ais 111, rdi 110 persistence detection
// RULE_17: oof after five bad, clears two good
// RULE_18: frame loss after 24 oof frames
// RULE_19: unmasked set flag drives event request
// RULE_20: masked flags still capture changes
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps

module rom_ctrl
	import rom_pkg::*;
(
	// clock, reset, enable
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               ce_i,
	// wishbone slave
	input  wire logic               cyc_i,
	input  wire logic               stb_i,
	input  wire logic               we_i,
	input  wire logic [11:0]        adr_i,
	input  wire logic [3:0]         sel_i,
	input  wire logic [31:0]        dat_i,
	output logic      [31:0]        dat_o,
	output logic                    ack_o,
	output logic                    err_o,
	// line side
	input  wire rom_pkg::rom_frame_t  frame_i,
	input  wire rom_pkg::rom_line_ev_t line_ev_i,
	input  wire logic               signal_loss_raw_i,
	// outputs to the datapath
	output logic                    event_req_o,
	output logic                    framer_enable_select_o,
	output logic [3:0]              frame_align_code_o,
	output logic                    rdi_from_signal_loss_o,
	output logic                    line_ais_state_o,
	output logic                    line_rdi_state_o,
	output logic                    out_of_frame_state_o,
	output logic                    frame_loss_state_o
);
	import rom_pkg::*;

	// ********************
	// registers
	// ********************
	logic [7:0] line_flags;      // line change flags
	logic [7:0] sect_flags;      // section change flags
	logic [7:0] line_masks;      // line report masks
	logic [7:0] sect_masks;      // section report masks
	logic [7:0] control;         // persistence count and control bits
	logic [3:0] align_code;      // frame pulse alignment
	logic [7:0] live_prev;       // previous event states for edge detection
	logic [3:0] ais_cnt;         // ais persistence run
	logic [3:0] rdi_cnt;         // rdi persistence run
	logic [2:0] oof_cnt;         // framing run counter
	logic [4:0] lof_cnt;         // frame loss run counter
	logic       line_ais_state;
	logic       line_rdi_state;
	logic       out_of_frame_state;
	logic       frame_loss_state;
	logic       signal_loss_state;

	// ********************
	// bus decode
	// ********************
	logic       req;             // new access this cycle
	logic       wr;              // write strobe with low lane enabled
	logic [9:0] idx;             // register index
	logic       hit;             // index maps to a register
	logic [7:0] wbyte;           // written byte
	logic [7:0] live_line;       // current line event bits
	logic [7:0] live_sect;       // current section event bits

	assign req   = cyc_i && stb_i && !ack_o && !err_o;
	assign idx   = adr_i[11:2];
	assign wbyte = dat_i[7:0];
	assign hit   = (idx == ROM_IDX_LINE_FLAGS) || (idx == ROM_IDX_SECT_FLAGS) ||
	               (idx == ROM_IDX_LINE_MASKS) || (idx == ROM_IDX_SECT_MASKS) ||
	               (idx == ROM_IDX_CONTROL) || (idx == ROM_IDX_ALIGN) || (idx == ROM_IDX_STATE);
	// a write lands at the edge where the master samples ack, never a cycle earlier
	assign wr    = ce_i && cyc_i && stb_i && ack_o && hit && we_i && sel_i[0];

	// ack one cycle after the request, err for unmapped addresses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
		end else if (ce_i) begin
			ack_o <= req && hit;
			err_o <= req && !hit;
		end
	end

	// read data registered; reserved bits read zero, except line mask bits 6,0, which read one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (ce_i && req) begin
			unique case (idx)
				ROM_IDX_LINE_FLAGS: dat_o <= {24'h000000, line_flags};
				ROM_IDX_SECT_FLAGS: dat_o <= {24'h000000, sect_flags};
				ROM_IDX_LINE_MASKS: dat_o <= {24'h000000, line_masks};
				ROM_IDX_SECT_MASKS: dat_o <= {24'h000000, sect_masks};
				ROM_IDX_CONTROL:    dat_o <= {24'h000000, control};
				ROM_IDX_ALIGN:      dat_o <= {28'h0000000, align_code};
				ROM_IDX_STATE:      dat_o <= {16'h0000, live_sect, live_line};
				default:            dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ********************
	// live event vectors
	// ********************
	always_comb begin
		live_line = 8'h00;
		live_line[ROM_LB_TRACE] = line_ev_i.trace_framing_state;
		live_line[ROM_LB_AIS]   = line_ais_state;
		live_line[ROM_LB_RDI]   = line_rdi_state;
		live_line[ROM_LB_K1U]   = line_ev_i.k1_instability_state;
		live_sect = 8'h00;
		live_sect[ROM_SB_LOS] = signal_loss_state;
		live_sect[ROM_SB_OOF] = out_of_frame_state;
		live_sect[ROM_SB_LOF] = frame_loss_state;
	end

	// remember previous states for change detection; loaded during reset too, so states
	// that reset to one do not look like a change on the first cycle after reset
	always_ff @(posedge clk_i) begin
		if (rst_i || ce_i) begin
			live_prev <= {live_line[ROM_LB_TRACE], live_line[ROM_LB_AIS], live_line[ROM_LB_RDI],
			              live_line[ROM_LB_K1U], live_sect[ROM_SB_LOS], live_sect[ROM_SB_OOF],
			              live_sect[ROM_SB_LOF], 1'b0};
		end
	end

	// ********************
	// change flags
	// ********************
	function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] set_v,
	                                         input logic [7:0] impl, input logic clr_en,
	                                         input logic [7:0] clr_v);
		logic [7:0] kept;
		kept = clr_en ? (cur & ~clr_v) : cur;
		flag_next = (kept | set_v) & impl; // set wins over clear
	endfunction : flag_next

	logic [7:0] line_set;       // line change events this cycle
	logic [7:0] sect_set;       // section change events this cycle
	always_comb begin
		line_set = 8'h00;
		line_set[ROM_LB_TRACE] = live_line[ROM_LB_TRACE] ^ live_prev[7]; // RULE_01
		line_set[ROM_LB_AIS]   = live_line[ROM_LB_AIS] ^ live_prev[6];
		line_set[ROM_LB_RDI]   = live_line[ROM_LB_RDI] ^ live_prev[5];
		line_set[ROM_LB_K1]    = line_ev_i.k1_change_pulse;
		line_set[ROM_LB_K1U]   = live_line[ROM_LB_K1U] ^ live_prev[4];
		line_set[ROM_LB_K2]    = line_ev_i.k2_change_pulse;
		sect_set = 8'h00;
		sect_set[ROM_SB_LOS] = live_sect[ROM_SB_LOS] ^ live_prev[3];
		sect_set[ROM_SB_OOF] = live_sect[ROM_SB_OOF] ^ live_prev[2];
		sect_set[ROM_SB_LOF] = live_sect[ROM_SB_LOF] ^ live_prev[1];
	end

	// flags capture regardless of mask; cleared only by writing one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_flags <= 8'h00;
			sect_flags <= 8'h00;
		end else if (ce_i) begin
			line_flags <= flag_next(line_flags, line_set, ROM_LINE_IMPL,
			                        wr && idx == ROM_IDX_LINE_FLAGS, wbyte); // RULE_02 RULE_04 RULE_20
			sect_flags <= flag_next(sect_flags, sect_set, ROM_SECT_IMPL,
			                        wr && idx == ROM_IDX_SECT_FLAGS, wbyte); // RULE_03 RULE_05 RULE_20
		end
	end

	// event request while any unmasked flag remains set
	assign event_req_o = |(line_flags & ~line_masks) || |(sect_flags & ~sect_masks); // RULE_06 RULE_19

	// ********************
	// configuration registers
	// ********************
	// reserved line mask bits are held at one whatever is written, so they never unmask
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_masks <= ROM_LINE_MASK_RST;
			sect_masks <= ROM_SECT_MASK_RST;
			control    <= ROM_CONTROL_RST; // RULE_08
			align_code <= ROM_ALIGN_RST; // RULE_14
		end else if (wr) begin
			if (idx == ROM_IDX_LINE_MASKS)
				line_masks <= wbyte | ~ROM_LINE_IMPL; // RULE_07
			if (idx == ROM_IDX_SECT_MASKS)
				sect_masks <= wbyte & ROM_SECT_IMPL;
			if (idx == ROM_IDX_CONTROL)
				control <= wbyte;
			// codes above 1011 are undefined and ignored
			if (idx == ROM_IDX_ALIGN && wbyte[3:0] <= ROM_ALIGN_MAX)
				align_code <= wbyte[3:0]; // RULE_15
		end
	end

	assign framer_enable_select_o = control[ROM_CB_FRM]; // RULE_11 RULE_12
	assign frame_align_code_o     = align_code;

	// ********************
	// signal loss conditioning
	// ********************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			signal_loss_state <= 1'b0;
		end else if (ce_i) begin
			signal_loss_state <= signal_loss_raw_i ^ control[ROM_CB_POL]; // RULE_09
		end
	end
	assign rdi_from_signal_loss_o = signal_loss_state && !control[ROM_CB_INH]; // RULE_10

	// ********************
	// line ais / rdi persistence
	// ********************
	// a run counts frames whose k2 pattern disagrees with the declared state
	function automatic logic [3:0] run_next(input logic [3:0] cnt, input logic differs);
		run_next = differs ? 4'(cnt + 4'd1) : 4'd0;
	endfunction : run_next

	logic [3:0] k2_need;        // persistence count
	logic       ais_seen;
	logic       rdi_seen;
	assign k2_need  = control[7:4];
	assign ais_seen = frame_i.k2_low == ROM_K2_AIS_CODE;
	assign rdi_seen = frame_i.k2_low == ROM_K2_RDI_CODE;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ais_cnt <= 4'd0;
			rdi_cnt <= 4'd0;
			line_ais_state <= 1'b1;
			line_rdi_state <= 1'b0;
		end else if (ce_i && frame_i.frame_pulse) begin
			ais_cnt <= run_next(ais_cnt, ais_seen != line_ais_state);
			rdi_cnt <= run_next(rdi_cnt, rdi_seen != line_rdi_state);
			if (ais_seen != line_ais_state && 4'(ais_cnt + 4'd1) >= k2_need) begin
				line_ais_state <= ais_seen; // RULE_16
				ais_cnt <= 4'd0;
			end
			if (rdi_seen != line_rdi_state && 4'(rdi_cnt + 4'd1) >= k2_need) begin
				line_rdi_state <= rdi_seen; // RULE_16
				rdi_cnt <= 4'd0;
			end
		end
	end

	// ********************
	// out of frame and frame loss
	// ********************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oof_cnt <= 3'd0;
			out_of_frame_state <= 1'b1;
		end else if (ce_i && frame_i.frame_pulse) begin
			if (frame_i.framing_ok == out_of_frame_state) begin
				if (3'(oof_cnt + 3'd1) >= (out_of_frame_state ? ROM_OOF_CLR_FRAMES : ROM_OOF_SET_FRAMES)) begin
					out_of_frame_state <= !out_of_frame_state; // RULE_17
					oof_cnt <= 3'd0;
				end else begin
					oof_cnt <= 3'(oof_cnt + 3'd1);
				end
			end else begin
				oof_cnt <= 3'd0;
			end
		end
	end

	logic [4:0] lof_need;       // frames needed to flip frame loss
	assign lof_need = frame_loss_state ?
	                  (control[ROM_CB_ALG] ? ROM_LOF_CLR_SHORT : ROM_LOF_CLR_LONG) : ROM_LOF_SET_FRAMES;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lof_cnt <= 5'd0;
			frame_loss_state <= 1'b1;
		end else if (ce_i && frame_i.frame_pulse) begin
			if (out_of_frame_state != frame_loss_state) begin
				if (5'(lof_cnt + 5'd1) >= lof_need) begin
					frame_loss_state <= out_of_frame_state; // RULE_13 RULE_18
					lof_cnt <= 5'd0;
				end else begin
					lof_cnt <= 5'(lof_cnt + 5'd1);
				end
			end else begin
				lof_cnt <= 5'd0;
			end
		end
	end

	assign line_ais_state_o     = line_ais_state;
	assign line_rdi_state_o     = line_rdi_state;
	assign out_of_frame_state_o = out_of_frame_state;
	assign frame_loss_state_o   = frame_loss_state;

endmodule : rom_ctrl

// [rom_pkg.sv]
// rom_pkg.sv: constants and carrier types for the receive overhead monitor register bank.
// assumes: byte-wide registers (the state register reads 16 bits) on a 32-bit classic wishbone bus, one word per register.
package rom_pkg;

	// ********************
	// register indices (byte address is four times the index)
	// ********************
	localparam logic [9:0] ROM_IDX_LINE_FLAGS    = 10'h0f9; // line overhead change flags, w1c
	localparam logic [9:0] ROM_IDX_SECT_FLAGS    = 10'h0fa; // section overhead change flags, w1c
	localparam logic [9:0] ROM_IDX_LINE_MASKS    = 10'h0fc; // line overhead report masks
	localparam logic [9:0] ROM_IDX_SECT_MASKS    = 10'h0fd; // section overhead report masks
	localparam logic [9:0] ROM_IDX_CONTROL       = 10'h0ff; // persistence, polarity, framer control
	localparam logic [9:0] ROM_IDX_ALIGN         = 10'h101; // frame pulse alignment code
	localparam logic [9:0] ROM_IDX_STATE         = 10'h102; // live event states

	// ********************
	// field positions
	// ********************
	localparam int ROM_LB_TRACE = 7; // trace framing
	localparam int ROM_LB_AIS   = 5; // line ais
	localparam int ROM_LB_RDI   = 4; // line rdi
	localparam int ROM_LB_K1    = 3; // k1 change
	localparam int ROM_LB_K1U   = 2; // k1 instability
	localparam int ROM_LB_K2    = 1; // k2 change
	localparam int ROM_SB_LOS   = 5; // signal loss
	localparam int ROM_SB_OOF   = 3; // out of frame
	localparam int ROM_SB_LOF   = 2; // frame loss
	localparam int ROM_CB_POL   = 3; // signal loss polarity
	localparam int ROM_CB_INH   = 2; // signal loss rdi inhibit
	localparam int ROM_CB_FRM   = 1; // framer enable select
	localparam int ROM_CB_ALG   = 0; // frame loss clear select

	// ********************
	// implemented bits and reset values
	// ********************
	localparam logic [7:0] ROM_LINE_IMPL   = 8'hbe; // bits 7,5..1
	localparam logic [7:0] ROM_SECT_IMPL   = 8'h2c; // bits 5,3,2
	localparam logic [7:0] ROM_LINE_MASK_RST = 8'hff;
	localparam logic [7:0] ROM_SECT_MASK_RST = 8'h2c;
	localparam logic [7:0] ROM_CONTROL_RST   = 8'h50;
	localparam logic [3:0] ROM_ALIGN_RST     = 4'h0;
	localparam logic [3:0] ROM_ALIGN_MAX     = 4'hb; // highest legal alignment code

	// ********************
	// frame counts
	// ********************
	localparam logic [4:0] ROM_LOF_SET_FRAMES   = 5'd24;
	localparam logic [4:0] ROM_LOF_CLR_LONG     = 5'd24;
	localparam logic [4:0] ROM_LOF_CLR_SHORT    = 5'd8;
	localparam logic [2:0] ROM_OOF_SET_FRAMES   = 3'd5;
	localparam logic [2:0] ROM_OOF_CLR_FRAMES   = 3'd2;
	localparam logic [2:0] ROM_K2_AIS_CODE      = 3'b111;
	localparam logic [2:0] ROM_K2_RDI_CODE      = 3'b110;

	// ********************
	// carrier: live event states from the detectors
	// ********************
	typedef struct packed {
		logic trace_framing_state;
		logic k1_change_pulse;      // k1 byte changed this frame
		logic k1_instability_state;
		logic k2_change_pulse;      // k2 byte changed this frame
	} rom_line_ev_t;

	typedef struct packed {
		logic frame_pulse;          // one cycle per received frame
		logic framing_ok;           // frame's framing pattern matched
		logic [2:0] k2_low;         // k2 bits 2..0 of this frame
	} rom_frame_t;

endpackage : rom_pkg

// [rom_line_model.sv]
// rom_line_model.sv: behavioural receive line source, one frame strobe every FRAME_CYC cycles.
// assumes: the bench sets the framing result and k2 bits; they are valid only with the strobe.
`timescale 1ns/1ps

module rom_line_model
	import rom_pkg::*;
#(
	parameter int FRAME_CYC = 8 // cycles per frame, far shorter than a real frame
)(
	// clock, reset, controls
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          run_i,
	input  wire logic          ok_i,
	input  wire logic [2:0]    k2_i,
	// frame carrier
	output rom_pkg::rom_frame_t frame_o
);
	int cnt; // cycle position within the frame

	// ********************
	// frame strobe
	// ********************
	// the source supplies the frame start itself, the framer may be bypassed
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i || cnt == FRAME_CYC - 1) begin
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end

	// between strobes the fields carry inverted junk, so a stray sample shows up
	always_comb begin
		frame_o.frame_pulse = run_i && !rst_i && cnt == FRAME_CYC - 1;
		frame_o.framing_ok  = frame_o.frame_pulse ? ok_i : !ok_i;
		frame_o.k2_low      = frame_o.frame_pulse ? k2_i : ~k2_i;
	end
endmodule : rom_line_model

// [rom_ctrl_properties.sv]
// rom_ctrl_properties.sv: port-level assertions for the overhead monitor register bank.
// assumes: bound into rom_ctrl; a write lands at the edge that samples ack.
`timescale 1ns/1ps

module rom_ctrl_props
	import rom_pkg::*;
(
	// clock and reset
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	// bus
	input  wire logic           ce_i,
	input  wire logic           cyc_i,
	input  wire logic           stb_i,
	input  wire logic           we_i,
	input  wire logic [11:0]    adr_i,
	input  wire logic [3:0]     sel_i,
	input  wire logic [31:0]    dat_i,
	input  wire logic           ack_o,
	input  wire logic           err_o,
	// line side and outputs
	input  wire rom_pkg::rom_frame_t frame_i,
	input  wire logic           signal_loss_raw_i,
	input  wire logic           event_req_o,
	input  wire logic           framer_enable_select_o,
	input  wire logic [3:0]     frame_align_code_o,
	input  wire logic           rdi_from_signal_loss_o,
	input  wire logic           line_ais_state_o,
	input  wire logic           frame_loss_state_o
);
	logic [7:0]      ctl; // shadow of the control register
	logic [3:0]      aln; // shadow of the alignment code
	logic            mwr; // a mask write was taken; until then every flag is masked
	wire logic       wr  = ce_i && ack_o && cyc_i && stb_i && we_i && sel_i[0];
	wire logic [9:0] idx = adr_i[11:2];

	// ********************
	// shadows of what software wrote
	// ********************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl <= ROM_CONTROL_RST;
			aln <= ROM_ALIGN_RST;
			mwr <= 1'b0;
		end else if (wr && idx == ROM_IDX_CONTROL) begin
			ctl <= dat_i[7:0];
		end else if (wr && idx == ROM_IDX_ALIGN && dat_i[3:0] <= ROM_ALIGN_MAX) begin
			aln <= dat_i[3:0]; // codes above the table are refused
		end else if (wr && (idx == ROM_IDX_LINE_MASKS || idx == ROM_IDX_SECT_MASKS)) begin
			mwr <= 1'b1;
		end
	end

	default clocking cb_main @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ********************
	// properties
	// ********************
	property p_answer; cyc_i && stb_i && ce_i && !ack_o && !err_o |=> ack_o ^ err_o; endproperty
	a_answer: assert property (p_answer) else $error("bus request not answered next cycle");
	property p_quiet; !mwr |-> !event_req_o; endproperty
	a_quiet: assert property (p_quiet) else $error("event request while all masks set");
	property p_pol; $stable(ctl) && !ctl[2] |-> rdi_from_signal_loss_o == ($past(signal_loss_raw_i) ^ ctl[3]); endproperty
	a_pol: assert property (p_pol) else $error("loss polarity wrong");
	property p_inh; ctl[2] |-> !rdi_from_signal_loss_o; endproperty
	a_inh: assert property (p_inh) else $error("inhibited loss reaches rdi");
	property p_framer; framer_enable_select_o == ctl[1]; endproperty
	a_framer: assert property (p_framer) else $error("framer select differs from control");
	property p_align; frame_align_code_o == aln; endproperty
	a_align: assert property (p_align) else $error("alignment code differs from written");
	property p_ais_frame; $changed(line_ais_state_o) |-> $past(frame_i.frame_pulse); endproperty
	a_ais_frame: assert property (p_ais_frame) else $error("ais moved without a frame");
	property p_lof_oof; $rose(frame_loss_state_o) |-> $past(frame_i.frame_pulse, 1); endproperty
	a_lof_oof: assert property (p_lof_oof) else $error("frame loss rose without a frame");

	c_event: cover property ($rose(event_req_o));
	c_ais: cover property ($fell(line_ais_state_o));
	c_lof: cover property ($rose(frame_loss_state_o));
endmodule : rom_ctrl_props

bind rom_ctrl rom_ctrl_props u_rom_ctrl_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .err_o(err_o),
	.frame_i(frame_i), .signal_loss_raw_i(signal_loss_raw_i), .event_req_o(event_req_o),
	.framer_enable_select_o(framer_enable_select_o), .frame_align_code_o(frame_align_code_o),
	.rdi_from_signal_loss_o(rdi_from_signal_loss_o), .line_ais_state_o(line_ais_state_o),
	.frame_loss_state_o(frame_loss_state_o));

// [rom_ctrl_tb.sv]
// rom_ctrl_tb.sv: self-checking bench for the overhead monitor register bank.
// assumes: rom_ctrl, rom_line_model and the bound checker are compiled first.
`timescale 1ns/1ps

module rom_ctrl_tb;
	import rom_pkg::*;
	logic         clk_i, rst_i, cyc, stb, we, run, ok, los, berr;
	logic [11:0]  adr;
	logic [3:0]   sel;
	logic [31:0]  dat;
	logic [2:0]   k2;
	logic [7:0]   q;
	rom_line_ev_t ev;
	rom_frame_t   frame;
	wire logic [31:0] rd;
	wire logic [3:0]  aln;
	wire logic    ack, err, req, fen, rdi, ais, lrdi, oof, lof;
	int           n_mismatch = 0, tests_run = 0, cycles = 0;

	rom_ctrl u_rom_ctrl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rd), .ack_o(ack), .err_o(err), .frame_i(frame),
		.line_ev_i(ev), .signal_loss_raw_i(los), .event_req_o(req), .framer_enable_select_o(fen),
		.frame_align_code_o(aln), .rdi_from_signal_loss_o(rdi), .line_ais_state_o(ais),
		.line_rdi_state_o(lrdi), .out_of_frame_state_o(oof), .frame_loss_state_o(lof));
	rom_line_model u_rom_line_model (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .ok_i(ok), .k2_i(k2),
		.frame_o(frame));

	// ********************
	// clock, timeout, verdict
	// ********************
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin // a hang counts as a failure
			n_mismatch++;
			stop_test();
		end
	end
	task stop_test();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test
	task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// ********************
	// bus and frame tasks
	// ********************
	// classic cycle: hold everything until ack or err is sampled, then release
	task bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= {idx, 2'b00};
		dat <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
		q = rd[7:0];
		berr = err;
		n_mismatch += (n == 50);
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		repeat (2) @(posedge clk_i); // the loss flop trails a control write by one edge
	endtask : bus
	task rdc(input string nm, input logic [9:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		check(nm, q, exp);
	endtask : rdc
	// comb outputs are looked at one edge after the call, three edges after a bus write lands
	task bc(input string nm, input logic s, input logic e);
		@(posedge clk_i);
		check(nm, {7'h0, s}, {7'h0, e});
	endtask : bc
	task frames(input int n);
		repeat (n) @(posedge clk_i iff frame.frame_pulse);
		repeat (3) @(posedge clk_i);
	endtask : frames

	initial begin
		{rst_i, cyc, stb, we, run, ok, los, adr, sel, dat, k2, ev} = {7'b1000010, 12'h0, 4'hf, 32'h0, 3'h0, 4'h0};
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rdc("line_masks", ROM_IDX_LINE_MASKS, 8'hff);
		rdc("control", ROM_IDX_CONTROL, 8'h50);
		rdc("line_flags", ROM_IDX_LINE_FLAGS, 8'h00);
		rdc("sect_flags", ROM_IDX_SECT_FLAGS, 8'h00);
		bus(1'b1, ROM_IDX_LINE_FLAGS, 8'hff);
		rdc("line_clr", ROM_IDX_LINE_FLAGS, 8'h00);
		sel <= 4'h0; // lane 0 off: the write is acked but dropped
		bus(1'b1, ROM_IDX_SECT_MASKS, 8'h00);
		sel <= 4'hf;
		rdc("sect_masks_sel", ROM_IDX_SECT_MASKS, 8'h2c);
		bus(1'b1, ROM_IDX_SECT_MASKS, 8'hff);
		rdc("sect_masks", ROM_IDX_SECT_MASKS, 8'h2c);
		bus(1'b1, ROM_IDX_LINE_MASKS, 8'h41);
		bc("req_idle", req, 1'b0);
		ev <= 4'h8;
		bc("req_trace", req, 1'b0);
		@(posedge clk_i);
		bc("req_trace", req, 1'b1);
		bus(1'b1, ROM_IDX_LINE_MASKS, 8'hff);
		bc("req_masked", req, 1'b0);
		ev <= 4'hf;
		@(posedge clk_i);
		ev <= 4'ha;
		bc("req_capture", req, 1'b0);
		rdc("line_capture", ROM_IDX_LINE_FLAGS, 8'h8e);
		bus(1'b1, ROM_IDX_LINE_MASKS, 8'hfd);
		bc("req_k2", req, 1'b1);
		bus(1'b1, ROM_IDX_LINE_FLAGS, 8'h02);
		bc("req_clr", req, 1'b0);
		bus(1'b1, ROM_IDX_CONTROL, 8'h39);
		bc("rdi_pol", rdi, 1'b1);
		rdc("sect_los", ROM_IDX_SECT_FLAGS, 8'h20);
		bus(1'b1, ROM_IDX_CONTROL, 8'h3f);
		bc("rdi_inh", rdi, 1'b0);
		bc("framer", fen, 1'b1);
		rdc("control", ROM_IDX_CONTROL, 8'h3f);
		for (int c = 0; c <= 12; c++) begin
			bus(1'b1, ROM_IDX_ALIGN, 8'(c));
			rdc("align", ROM_IDX_ALIGN, (c > 11) ? 8'h0b : 8'(c));
		end
		check("align_out", {4'h0, aln}, 8'h0b);
		bus(1'b0, 10'h0a0, 8'h00);
		check("unmapped", {7'h0, berr}, 8'h01);
		run <= 1'b1;
		frames(1);
		bc("oof_hold", oof, 1'b1);
		frames(1);
		bc("ais_hold", ais, 1'b1);
		frames(1);
		bc("oof_clr", oof, 1'b0);
		frames(1);
		bc("ais_clr", ais, 1'b0);
		frames(5);
		bc("lof_hold", lof, 1'b1);
		frames(1);
		bc("lof_clr8", lof, 1'b0);
		rdc("sect_all", ROM_IDX_SECT_FLAGS, 8'h2c);
		bus(1'b1, ROM_IDX_SECT_FLAGS, 8'h08);
		rdc("sect_one", ROM_IDX_SECT_FLAGS, 8'h24);
		k2 <= 3'b110;
		frames(2);
		bc("rdi_wait", lrdi, 1'b0);
		frames(2);
		bc("rdi_set", lrdi, 1'b1);
		ok <= 1'b0;
		frames(4);
		bc("oof_wait", oof, 1'b0);
		frames(2);
		bc("oof_set", oof, 1'b1);
		frames(22);
		bc("lof_wait", lof, 1'b0);
		frames(1);
		bc("lof_set", lof, 1'b1);
		bus(1'b1, ROM_IDX_CONTROL, 8'h3e);
		ok <= 1'b1;
		frames(25);
		bc("lof_hold24", lof, 1'b1);
		frames(1);
		bc("lof_clr24", lof, 1'b0);
		stop_test();
	end
endmodule : rom_ctrl_tb
